// >>> flash_ctrl_defines.vh
`ifndef FLASH_CTRL_DEFINES_VH
`define FLASH_CTRL_DEFINES_VH

// ==================================================
// bus layout
`define ADDR_W            12
`define DATA_W            32
`define TPTR_W            21
`define OFS_CONTROL       12'h000
`define OFS_IRQ_STATUS    12'h004
`define OFS_IRQ_MASK      12'h008
`define OFS_TPTR_LATCH    12'h00c

// ==================================================
// control register fields
`define CTL_W             8
`define CTL_RESET         8'h00
`define BIT_ROW_ERASE     4
`define BIT_WRITE_ERROR   3
`define BIT_WRITE_ENABLE  2
`define BIT_START         1

// ==================================================
// interrupt events
`define IRQ_W             2
`define IRQ_RESET         2'h0
`define IRQ_DONE          0
`define IRQ_ERROR         1

// ==================================================
// timing
`define CLK_MHZ           50
`define ERASE_TIME_US     1000
`define WRITE_TIME_US     50
`define ERASE_CYCLES      (`ERASE_TIME_US * `CLK_MHZ)
`define WRITE_CYCLES      (`WRITE_TIME_US * `CLK_MHZ)
`define CNT_W             24

`endif

// >>> cycle_timer.v
`include "flash_ctrl_defines.vh"

// ==================================================
// self-timed countdown
module cycle_timer (
  input  wire               clk,
  input  wire               reset_n,
  input  wire               load,
  input  wire               abort,
  input  wire [`CNT_W-1:0]  count,
  output reg                expired_ff
);

  reg  [`CNT_W-1:0] remain_ff;
  reg               run_ff;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remain_ff  <= {`CNT_W{1'b0}};
      run_ff     <= 1'b0;
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= 1'b0;
      if (abort) begin
        run_ff <= 1'b0;
      end else if (load) begin
        remain_ff <= count;
        run_ff    <= 1'b1;
      end else if (run_ff) begin
        if (remain_ff <= {{(`CNT_W-1){1'b0}}, 1'b1}) begin
          run_ff     <= 1'b0;
          expired_ff <= 1'b1;
        end else begin
          remain_ff <= remain_ff - {{(`CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // cycle_timer

// >>> program_flash_write_control.v
`include "flash_ctrl_defines.vh"

module program_flash_write_control #(
  parameter [`CNT_W-1:0] ERASE_CYCLES = `ERASE_CYCLES,
  parameter [`CNT_W-1:0] WRITE_CYCLES = `WRITE_CYCLES
) (
  input  wire               clk,
  input  wire               reset_n,
  input  wire               warm_reset_n,
  input  wire [`TPTR_W-1:0] table_pointer,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [`ADDR_W-1:0] paddr,
  input  wire [`DATA_W-1:0] pwdata,
  output reg  [`DATA_W-1:0] prdata_ff,
  output reg                pready_ff,
  output reg                pslverr_ff,
  output reg                irq_ff,
  output reg                flash_erase_ff,
  output reg                flash_program_ff,
  output reg  [`TPTR_W-1:0] flash_addr_ff
);

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_ERASE = 3'b010;
  localparam [2:0] ST_WRITE = 3'b100;

  // ==================================================
  // warm reset synchroniser
  // warm reset is a pin level; it aborts a running cycle instead of clearing the error flag
  reg warm_meta_ff;
  reg warm_sync_ff;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      warm_meta_ff <= 1'b1;
      warm_sync_ff <= 1'b1;
    end else begin
      warm_meta_ff <= warm_reset_n;
      warm_sync_ff <= warm_meta_ff;
    end
  end

  wire warm_active = ~warm_sync_ff;

  // ==================================================
  // state
  reg [2:0]         state_ff;
  reg [2:0]         nxt_state;
  reg               row_erase_ff;
  reg               nxt_row_erase;
  reg               write_error_ff;
  reg               nxt_write_error;
  reg               write_enable_ff;
  reg               nxt_write_enable;
  reg               start_ff;
  reg               nxt_start;
  reg [`IRQ_W-1:0]  irq_status_ff;
  reg [`IRQ_W-1:0]  nxt_irq_status;
  reg [`IRQ_W-1:0]  irq_mask_ff;
  reg [`IRQ_W-1:0]  nxt_irq_mask;
  reg [`TPTR_W-1:0] nxt_flash_addr;
  reg               timer_load;
  reg [`CNT_W-1:0]  timer_count;
  reg               ev_done;
  reg               ev_error;
  wire              timer_expired;

  // ==================================================
  // bus decode
  // a write lands on the edge where pready is seen high; read data is registered on the edge that raises pready
  wire bus_access = psel & penable & pready_ff;
  wire bus_wr     = bus_access & pwrite;
  wire hit_ctl    = (paddr == `OFS_CONTROL);
  wire hit_stat   = (paddr == `OFS_IRQ_STATUS);
  wire hit_mask   = (paddr == `OFS_IRQ_MASK);
  wire hit_tptr   = (paddr == `OFS_TPTR_LATCH);
  wire mapped     = hit_ctl | hit_stat | hit_mask | hit_tptr;
  wire wr_ctl     = bus_wr & hit_ctl;
  wire busy       = ~state_ff[0];

  wire [`CTL_W-1:0] ctl_view = {3'h0,
                                row_erase_ff,
                                write_error_ff,
                                write_enable_ff,
                                start_ff,
                                1'b0};

  // ==================================================
  // sequencer
  always @* begin
    nxt_state        = state_ff;
    nxt_row_erase    = row_erase_ff;
    nxt_write_error  = write_error_ff;
    nxt_write_enable = write_enable_ff;
    nxt_start        = start_ff;
    nxt_flash_addr   = flash_addr_ff;
    timer_load       = 1'b0;
    timer_count      = WRITE_CYCLES;
    ev_done          = 1'b0;
    ev_error         = 1'b0;

    // only bits 4..1 are stored; the rest of pwdata is dropped
    if (wr_ctl) begin
      nxt_write_enable = pwdata[`BIT_WRITE_ENABLE];
      nxt_write_error  = pwdata[`BIT_WRITE_ERROR];
      if (!busy) begin
        nxt_row_erase = pwdata[`BIT_ROW_ERASE];
      end
    end

    case (state_ff)
      ST_IDLE: begin
        if (wr_ctl && pwdata[`BIT_START]) begin
          if (pwdata[`BIT_WRITE_ENABLE] && !warm_active) begin
            nxt_start      = 1'b1;
            nxt_flash_addr = table_pointer;
            timer_load     = 1'b1;
            if (pwdata[`BIT_ROW_ERASE]) begin
              nxt_state   = ST_ERASE;
              timer_count = ERASE_CYCLES;
            end else begin
              nxt_state   = ST_WRITE;
              timer_count = WRITE_CYCLES;
            end
          end else begin
            nxt_start       = 1'b0;
            nxt_write_error = 1'b1;
            ev_error        = 1'b1;
          end
        end
      end
      ST_ERASE, ST_WRITE: begin
        if (warm_active) begin
          nxt_state       = ST_IDLE;
          nxt_start       = 1'b0;
          nxt_row_erase   = 1'b0;
          nxt_write_error = 1'b1;
          ev_error        = 1'b1;
        end else if (timer_expired) begin
          nxt_state = ST_IDLE;
          nxt_start = 1'b0;
          ev_done   = 1'b1;
          if (state_ff == ST_ERASE) begin
            nxt_row_erase = 1'b0;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_start = 1'b0;
      end
    endcase

    if (warm_active && !busy) begin
      nxt_start     = 1'b0;
      nxt_row_erase = 1'b0;
    end
  end

  // ==================================================
  // interrupt registers
  // set beats write-one-to-clear in the same cycle
  always @* begin
    nxt_irq_status = irq_status_ff;
    nxt_irq_mask   = irq_mask_ff;
    if (bus_wr && hit_stat) begin
      nxt_irq_status = irq_status_ff & ~pwdata[`IRQ_W-1:0];
    end
    if (bus_wr && hit_mask) begin
      nxt_irq_mask = pwdata[`IRQ_W-1:0];
    end
    nxt_irq_status[`IRQ_DONE]  = nxt_irq_status[`IRQ_DONE] | ev_done;
    nxt_irq_status[`IRQ_ERROR] = nxt_irq_status[`IRQ_ERROR] | ev_error;
  end

  cycle_timer u_timer (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (timer_load),
    .abort      (warm_active),
    .count      (timer_count),
    .expired_ff (timer_expired)
  );

  // ==================================================
  // registers and flash strobes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff         <= ST_IDLE;
      row_erase_ff     <= 1'b0;
      write_error_ff   <= 1'b0;
      write_enable_ff  <= 1'b0;
      start_ff         <= 1'b0;
      irq_status_ff    <= `IRQ_RESET;
      irq_mask_ff      <= `IRQ_RESET;
      irq_ff           <= 1'b0;
      flash_erase_ff   <= 1'b0;
      flash_program_ff <= 1'b0;
      flash_addr_ff    <= {`TPTR_W{1'b0}};
    end else begin
      state_ff         <= nxt_state;
      row_erase_ff     <= nxt_row_erase;
      write_error_ff   <= nxt_write_error;
      write_enable_ff  <= nxt_write_enable;
      start_ff         <= nxt_start;
      irq_status_ff    <= nxt_irq_status;
      irq_mask_ff      <= nxt_irq_mask;
      irq_ff           <= |(nxt_irq_status & nxt_irq_mask);
      flash_erase_ff   <= nxt_state[1];
      flash_program_ff <= nxt_state[2];
      flash_addr_ff    <= nxt_flash_addr;
    end
  end

  // ==================================================
  // apb slave: one wait state, then ready
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= {`DATA_W{1'b0}};
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
      if (psel && penable && !pready_ff && !pwrite) begin
        if (hit_ctl) begin
          prdata_ff <= {{(`DATA_W-`CTL_W){1'b0}}, ctl_view};
        end else if (hit_stat) begin
          prdata_ff <= {{(`DATA_W-`IRQ_W){1'b0}}, irq_status_ff};
        end else if (hit_mask) begin
          prdata_ff <= {{(`DATA_W-`IRQ_W){1'b0}}, irq_mask_ff};
        end else if (hit_tptr) begin
          prdata_ff <= {{(`DATA_W-`TPTR_W){1'b0}}, flash_addr_ff};
        end else begin
          prdata_ff <= {`DATA_W{1'b0}};
        end
      end else begin
        prdata_ff <= {`DATA_W{1'b0}};
      end
    end
  end

endmodule // program_flash_write_control

// >>> program_flash_write_control_props.sv
`include "flash_ctrl_defines.vh"
module flash_ctrl_props #(
  parameter [`CNT_W-1:0] ERASE_CYCLES = `ERASE_CYCLES,
  parameter [`CNT_W-1:0] WRITE_CYCLES = `WRITE_CYCLES
) (
  input wire               clk,
  input wire               reset_n,
  input wire               warm_reset_n,
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [`DATA_W-1:0] pwdata,
  input wire [`DATA_W-1:0] prdata_ff,
  input wire               pready_ff,
  input wire               flash_erase_ff,
  input wire               flash_program_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // helpers
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire              idle = !flash_erase_ff && !flash_program_ff;
  wire              acc  = psel && penable && pready_ff && paddr == `OFS_CONTROL;
  wire              go   = acc && pwrite && pwdata[`BIT_START] && idle;
  reg  [`CNT_W-1:0] run_ff;
  // strobe length, counted so that long cycle figures need no repetition
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) run_ff <= {`CNT_W{1'b0}};
    else run_ff <= idle ? {`CNT_W{1'b0}} : run_ff + 1'b1;
  end
  // warm reset passes a 2-flop synchroniser, so look six samples back
  sequence s_calm;
    warm_reset_n [*6];
  endsequence
  sequence s_go_on;
    s_calm ##0 (go && pwdata[`BIT_WRITE_ENABLE]);
  endsequence
  // ==========
  // properties
  a_erase_launch: assert property (s_go_on ##0 pwdata[`BIT_ROW_ERASE] |=> flash_erase_ff)
    else $error("erase strobe missing after start");
  a_write_only: assert property (s_go_on ##0 !pwdata[`BIT_ROW_ERASE] |=> flash_program_ff && !flash_erase_ff)
    else $error("write start did not give a write only");
  a_start_blocked: assert property (go && !pwdata[`BIT_WRITE_ENABLE] |=> idle [*3])
    else $error("cycle launched without write enable");
  a_one_strobe: assert property (!(flash_erase_ff && flash_program_ff))
    else $error("erase and write strobes together");
  a_write_timed: assert property (s_calm ##0 $fell(flash_program_ff) |->
    run_ff >= WRITE_CYCLES && run_ff <= WRITE_CYCLES + 1'b1)
    else $error("write strobe length wrong");
  a_erase_timed: assert property (s_calm ##0 $fell(flash_erase_ff) |->
    run_ff >= ERASE_CYCLES && run_ff <= ERASE_CYCLES + 1'b1)
    else $error("erase strobe length wrong");
  a_busy_start: assert property (acc && !pwrite && !idle |-> prdata_ff[`BIT_START])
    else $error("start reads zero while busy");
  a_busy_row: assert property (acc && !pwrite && flash_erase_ff |-> prdata_ff[`BIT_ROW_ERASE])
    else $error("row erase select lost during erase");
  a_idle_start: assert property (idle [*3] ##0 (acc && !pwrite) |-> !prdata_ff[`BIT_START])
    else $error("start reads one while idle");
  a_unused_zero: assert property (acc && !pwrite |-> prdata_ff[31:5] == 27'h0 && !prdata_ff[0])
    else $error("unused control bits not zero");
endmodule // flash_ctrl_props
bind program_flash_write_control flash_ctrl_props #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .clk, .reset_n, .warm_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
  .flash_erase_ff, .flash_program_ff);

// >>> program_flash_write_control_tb.sv
`include "flash_ctrl_defines.vh"
module program_flash_write_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 0;
  logic               reset_n = 0;
  logic               warm_reset_n = 1;
  logic [`TPTR_W-1:0] table_pointer = 0;
  logic               psel = 0;
  logic               penable = 0;
  logic               pwrite = 0;
  logic [`ADDR_W-1:0] paddr = 0;
  logic [`DATA_W-1:0] pwdata = 0;
  logic [`DATA_W-1:0] rd;
  logic [`DATA_W-1:0] w;
  logic               err;
  wire  [`DATA_W-1:0] prdata_ff;
  wire                pready_ff, pslverr_ff, irq_ff, flash_erase_ff, flash_program_ff;
  wire  [`TPTR_W-1:0] flash_addr_ff;
  int                 n_fail = 0;
  int                 n_checks = 0;
  always #10 clk = ~clk;
  program_flash_write_control #(.ERASE_CYCLES(16), .WRITE_CYCLES(6)) dut (
    .clk, .reset_n, .warm_reset_n, .table_pointer, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_ff, .pready_ff, .pslverr_ff, .irq_ff, .flash_erase_ff, .flash_program_ff, .flash_addr_ff);
  // ==========
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready_ff !== 1'b1 && k < 50);
    if (k >= 50) n_fail++;
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((flash_erase_ff | flash_program_ff) !== 1'b0 && k < 100);
    if (k >= 100) n_fail++;
  endtask
  // only control bits 4..2 survive an idle write that leaves start clear
  function automatic logic [31:0] ctl_kept(input logic [31:0] v);
    return v & 32'h1c;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
  // ==========
  // tests
  initial begin
    void'($urandom(79426));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(`OFS_CONTROL, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("test reset done");
    repeat (8) begin
      w = $urandom & ~32'h2;
      apb(1'b1, `OFS_CONTROL, w);
      rdchk(`OFS_CONTROL, ctl_kept(w));
    end
    $display("test fields done");
    apb(1'b1, `OFS_IRQ_MASK, 32'h3);
    table_pointer <= `TPTR_W'($urandom);
    apb(1'b1, `OFS_CONTROL, 32'h6);
    rdchk(`OFS_CONTROL, 32'h6);
    check(flash_addr_ff, table_pointer);
    rdchk(`OFS_TPTR_LATCH, table_pointer);
    wait_idle;
    rdchk(`OFS_CONTROL, 32'h4);
    check(irq_ff, 1'b1);
    rdchk(`OFS_IRQ_STATUS, 32'h1);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
    // irq_ff only drops at the edge where the clear lands
    @(posedge clk);
    check(irq_ff, 1'b0);
    $display("test write done");
    apb(1'b1, `OFS_CONTROL, 32'h16);
    apb(1'b1, `OFS_CONTROL, 32'h4);
    rdchk(`OFS_CONTROL, 32'h16);
    wait_idle;
    rdchk(`OFS_CONTROL, 32'h4);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h3);
    $display("test erase done");
    apb(1'b1, `OFS_CONTROL, 32'h12);
    rdchk(`OFS_CONTROL, 32'h18);
    rdchk(`OFS_IRQ_STATUS, 32'h2);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    @(posedge clk);
    check(irq_ff, 1'b0);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    $display("test blocked done");
    apb(1'b1, `OFS_CONTROL, 32'h16);
    warm_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    warm_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(flash_erase_ff, 1'b0);
    rdchk(`OFS_CONTROL, 32'hc);
    $display("test warm reset done");
    apb(1'b1, `OFS_CONTROL, 32'h6);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(`OFS_CONTROL, 32'h0);
    $display("test full reset done");
    print_verdict;
  end
endmodule // program_flash_write_control_tb
